// ==== hw/speed_sdo_defs.vh ====
/*
  Constants for the speed and SDO command unit: register offsets, field
  positions, reset values and state codes.
  Assumes inclusion by bare name from the design file and the bench.
*/
`ifndef SPEED_SDO_DEFS_VH
`define SPEED_SDO_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL      6'h00
`define OFS_SPEED_COMMAND_OP      6'h04
`define OFS_ACCEL     6'h08
`define OFS_DECEL     6'h0C
`define OFS_PRECLEAR  6'h10
`define OFS_STATUS    6'h14
`define OFS_SDO_NODE  6'h18
`define OFS_SDO_INDEX 6'h1C
`define OFS_SDO_SUB   6'h20
`define OFS_SDO_DATA  6'h24
`define OFS_SDO_CMD   6'h28
`define OFS_SDO_RESULT 6'h2C
`define OFS_ERR0      6'h30
`define OFS_ERR1      6'h34
`define OFS_ERR2      6'h38
`define OFS_ERR3      6'h3C

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTRL_RUN      0
`define CTRL_DIR      1
`define CTRL_SERVO    2
`define CTRL_QSTOP    3
`define CTRL_PAUSE    4
`define CTRL_LOCK     5
`define CTRL_SPEED_EN 6
`define CTRL_SCAN     7
`define CTRL_RESET    8'h00

// ----------------------------------------------------------------
// Preclear configuration fields
// ----------------------------------------------------------------
`define PCL_SPEED_COMMAND_OP      0
`define PCL_TORQUE    1
`define PCL_TLIMIT    2
`define PCL_RESET     16'h0000

// ----------------------------------------------------------------
// SDO command register fields
// ----------------------------------------------------------------
`define CMD_GO        0
`define CMD_WRITE     1
`define CMD_PULSE     2

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define ST_DONE       0
`define ST_OK         1
`define ST_REACHED    2
`define ST_BUSY       3

// ----------------------------------------------------------------
// Transfer states
// ----------------------------------------------------------------
`define S_IDLE        2'h0
`define S_REQ         2'h1
`define S_WAIT        2'h2

`endif

// ==== hw/speed_sdo_unit.v ====
/*
  Speed command and SDO transfer unit of a drive's built-in controller.
  Holds the speed command, control bits and preclear configuration, and
  runs one SDO upload or download at a time toward a CANopen engine.
  Assumes a classic Wishbone master, a drive core that consumes the
  command outputs, and an SDO engine with a req/ack style handshake.
*/
`timescale 1ns/1ps
`include "speed_sdo_defs.vh"

module speed_sdo_unit #(
  parameter SPEED_COMMAND_OP_W = 16,
  parameter TIME_W = 16,
  parameter DATA_W = 32
) (
  // Clock and reset
  input  wire              clk_i,
  input  wire              rst_i,
  // Wishbone slave
  input  wire              cyc_i,
  input  wire              stb_i,
  input  wire              we_i,
  input  wire [5:0]        adr_i,
  input  wire [3:0]        sel_i,
  input  wire [31:0]       dat_i,
  output reg  [31:0]       dat_o,
  output reg               ack_o,
  // Drive core
  input  wire              speed_command_op_reached_i,
  output reg  [SPEED_COMMAND_OP_W-1:0] speed_command_op_cmd_o,
  output reg  [TIME_W-1:0] accel_time_o,
  output reg  [TIME_W-1:0] decel_time_o,
  output reg               run_o,
  output reg               reverse_o,
  output reg               servo_on_o,
  output reg               quick_stop_o,
  output reg               pause_o,
  output reg               speed_command_op_lock_o,
  output reg               torque_clear_o,
  output reg               limit_clear_o,
  // SDO engine
  output reg               sdo_req_o,
  output reg               sdo_write_o,
  output reg  [6:0]        sdo_node_o,
  output reg  [15:0]       sdo_index_o,
  output reg  [15:0]       sdo_sub_o,
  output reg  [DATA_W-1:0] sdo_wdata_o,
  input  wire              sdo_ack_i,
  input  wire              sdo_done_i,
  input  wire              sdo_error_i,
  input  wire [DATA_W-1:0] sdo_rdata_i,
  input  wire [63:0]       sdo_err_info_i
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0]        ctrl;
  reg [SPEED_COMMAND_OP_W-1:0] speed_command_op_op;
  reg [TIME_W-1:0] accel_op;
  reg [TIME_W-1:0] decel_op;
  reg [15:0]       preclear;
  reg [6:0]        node;
  reg [15:0]       index;
  reg [15:0]       sub;
  reg [DATA_W-1:0] data;
  reg [2:0]        cmd;
  reg [DATA_W-1:0] result;
  wire [15:0]      err_word [0:3];
  reg              transfer_done_flag;
  reg              transfer_ok_flag;
  reg              speed_command_op_reached_flag;
  reg [1:0]        state;
  reg              go_prev;
  reg [31:0]       next_dat;

  wire bus_req  = cyc_i & stb_i & ~ack_o;
  wire bus_wr   = bus_req & we_i;
  wire scan     = bus_wr & (adr_i == `OFS_CTRL) & sel_i[0];
  wire cmd_wr   = bus_wr & (adr_i == `OFS_SDO_CMD) & sel_i[0];
  wire go_level = cmd[`CMD_GO];

  // ----------------------------------------------------------------
  // Command start detection
  // ----------------------------------------------------------------
  // Pulse or continuous
  wire go_event = cmd[`CMD_PULSE] ? (go_level & ~go_prev) : go_level;
  wire start    = go_event & (state == `S_IDLE);

  // ----------------------------------------------------------------
  // Bus write side and scan reference handling
  // ----------------------------------------------------------------
  // A write to the control byte marks a new program scan; the preclear
  // bits act at that moment so the speed operand written in the same
  // scan wins when the enable bit is set.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl     <= `CTRL_RESET;
      speed_command_op_op  <= {SPEED_COMMAND_OP_W{1'b0}};
      accel_op <= {TIME_W{1'b0}};
      decel_op <= {TIME_W{1'b0}};
      preclear <= `PCL_RESET;
      node     <= 7'h00;
      index    <= 16'h0000;
      sub      <= 16'h0000;
      data     <= {DATA_W{1'b0}};
      cmd      <= 3'h0;
    end else begin
      if (bus_wr) begin
        case (adr_i)
          `OFS_CTRL:      if (sel_i[0]) ctrl <= dat_i[7:0];
          `OFS_SPEED_COMMAND_OP:      speed_command_op_op <= dat_i[SPEED_COMMAND_OP_W-1:0];
          `OFS_ACCEL:     accel_op <= dat_i[TIME_W-1:0];
          `OFS_DECEL:     decel_op <= dat_i[TIME_W-1:0];
          `OFS_PRECLEAR:  preclear <= dat_i[15:0];
          `OFS_SDO_NODE:  node <= dat_i[6:0];
          `OFS_SDO_INDEX: index <= dat_i[15:0];
          `OFS_SDO_SUB:   sub <= dat_i[15:0];
          `OFS_SDO_DATA:  data <= dat_i[DATA_W-1:0];
          `OFS_SDO_CMD:   if (sel_i[0]) cmd <= dat_i[2:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Drive command outputs
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      speed_command_op_cmd_o     <= {SPEED_COMMAND_OP_W{1'b0}};
      accel_time_o   <= {TIME_W{1'b0}};
      decel_time_o   <= {TIME_W{1'b0}};
      run_o          <= 1'b0;
      reverse_o      <= 1'b0;
      servo_on_o     <= 1'b0;
      quick_stop_o   <= 1'b0;
      pause_o        <= 1'b0;
      speed_command_op_lock_o    <= 1'b0;
      torque_clear_o <= 1'b0;
      limit_clear_o  <= 1'b0;
    end else begin
      run_o        <= ctrl[`CTRL_RUN] & ctrl[`CTRL_SERVO];
      reverse_o    <= ctrl[`CTRL_DIR];
      servo_on_o   <= ctrl[`CTRL_SERVO];
      quick_stop_o <= ctrl[`CTRL_QSTOP];
      pause_o      <= ctrl[`CTRL_PAUSE];
      speed_command_op_lock_o  <= ctrl[`CTRL_LOCK];
      torque_clear_o <= scan & preclear[`PCL_TORQUE];
      limit_clear_o  <= scan & preclear[`PCL_TLIMIT];
      if (scan & dat_i[`CTRL_SPEED_EN]) begin
        speed_command_op_cmd_o   <= speed_command_op_op;
        accel_time_o <= accel_op;
        decel_time_o <= decel_op;
      end else if (scan & preclear[`PCL_SPEED_COMMAND_OP]) begin
        speed_command_op_cmd_o <= {SPEED_COMMAND_OP_W{1'b0}};
      end
    end
  end

  // ----------------------------------------------------------------
  // SDO transfer sequencer
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      state              <= `S_IDLE;
      go_prev            <= 1'b0;
      sdo_req_o          <= 1'b0;
      sdo_write_o        <= 1'b0;
      sdo_node_o         <= 7'h00;
      sdo_index_o        <= 16'h0000;
      sdo_sub_o          <= 16'h0000;
      sdo_wdata_o        <= {DATA_W{1'b0}};
      result             <= {DATA_W{1'b0}};
      transfer_done_flag <= 1'b0;
      transfer_ok_flag   <= 1'b0;
    end else begin
      // In pulse mode a go that arrives while busy is dropped rather than queued, so
      // the program must wait for the done flag before its next one.
      go_prev <= go_level;
      case (state)
        `S_IDLE: begin
          if (start) begin
            transfer_done_flag <= 1'b0;
            transfer_ok_flag   <= 1'b0;
            sdo_req_o   <= 1'b1;
            sdo_write_o <= cmd[`CMD_WRITE];
            sdo_node_o  <= node;
            sdo_index_o <= index;
            sdo_sub_o   <= sub;
            sdo_wdata_o <= data;
            state       <= `S_REQ;
          end
        end
        `S_REQ: begin
          if (sdo_ack_i) begin
            sdo_req_o <= 1'b0;
            state     <= `S_WAIT;
          end
        end
        `S_WAIT: begin
          if (sdo_done_i) begin
            transfer_done_flag <= 1'b1;
            if (!sdo_error_i) begin
              transfer_ok_flag <= 1'b1;
              if (!sdo_write_o)
                result <= sdo_rdata_i;
            end
            state <= `S_IDLE;
          end
        end
        default: state <= `S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Error record words
  // ----------------------------------------------------------------
  // A failed exchange overwrites all four words at once, so software
  // never sees a mix of two error reports.
  // Capture on bad reply
  wire err_load = (state == `S_WAIT) & sdo_done_i & sdo_error_i;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_err
      reg [15:0] saved;
      always @(posedge clk_i) begin
        if (rst_i)
          saved <= 16'h0000;
        else if (err_load)
          saved <= sdo_err_info_i[16*gi +: 16];
      end
      assign err_word[gi] = saved;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Frequency reached flag
  // ----------------------------------------------------------------
  // The drive core's level is registered here so that a status read
  // and the flag it reports belong to one and the same clock cycle.
  // Registered reached flag
  always @(posedge clk_i) begin
    if (rst_i)
      speed_command_op_reached_flag <= 1'b0;
    else
      speed_command_op_reached_flag <= speed_command_op_reached_i;
  end

  // ----------------------------------------------------------------
  // Bus read side
  // ----------------------------------------------------------------
  always @* begin
    next_dat = 32'h0000_0000;
    case (adr_i)
      `OFS_CTRL:       next_dat[7:0] = ctrl;
      `OFS_SPEED_COMMAND_OP:       next_dat[SPEED_COMMAND_OP_W-1:0] = speed_command_op_op;
      `OFS_ACCEL:      next_dat[TIME_W-1:0] = accel_op;
      `OFS_DECEL:      next_dat[TIME_W-1:0] = decel_op;
      `OFS_PRECLEAR:   next_dat[15:0] = preclear;
      `OFS_STATUS: begin
        next_dat[`ST_DONE]    = transfer_done_flag;
        next_dat[`ST_OK]      = transfer_ok_flag;
        next_dat[`ST_REACHED] = speed_command_op_reached_flag;
        next_dat[`ST_BUSY]    = (state != `S_IDLE);
      end
      `OFS_SDO_NODE:   next_dat[6:0] = node;
      `OFS_SDO_INDEX:  next_dat[15:0] = index;
      `OFS_SDO_SUB:    next_dat[15:0] = sub;
      `OFS_SDO_DATA:   next_dat[DATA_W-1:0] = data;
      `OFS_SDO_CMD:    next_dat[2:0] = cmd;
      `OFS_SDO_RESULT: next_dat[DATA_W-1:0] = result;
      `OFS_ERR0:       next_dat[15:0] = err_word[0];
      `OFS_ERR1:       next_dat[15:0] = err_word[1];
      `OFS_ERR2:       next_dat[15:0] = err_word[2];
      `OFS_ERR3:       next_dat[15:0] = err_word[3];
      default:         next_dat = 32'h0000_0000;
    endcase
  end

  // Every access, mapped or not, is answered one cycle later so that a
  // stray address never hangs the master; unmapped reads give zero.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req;
      if (bus_req & ~we_i)
        dat_o <= next_dat;
    end
  end

endmodule

// ==== testbench/speed_sdo_chk.sv ====
/* Port checker for speed_sdo_unit.
   Assumes the bind below and one clock with a synchronous reset. */
`timescale 1ns/1ps
module speed_sdo_chk (
  input wire        clk_i,
  input wire        rst_i,
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [5:0]  adr_i,
  input wire [3:0]  sel_i,
  input wire [31:0] dat_i,
  input wire        ack_o,
  input wire        run_o,
  input wire        reverse_o,
  input wire        servo_on_o,
  input wire        quick_stop_o,
  input wire        pause_o,
  input wire        speed_command_op_lock_o,
  input wire        torque_clear_o,
  input wire        limit_clear_o,
  input wire        sdo_req_o,
  input wire        sdo_write_o,
  input wire [6:0]  sdo_node_o,
  input wire [15:0] sdo_index_o,
  input wire [15:0] sdo_sub_o,
  input wire        sdo_ack_i,
  input wire        sdo_done_i
);
  // ----------------------------------------
  // Shadow state
  // ----------------------------------------
  logic [7:0] ctl;
  logic       busy;
  wire        scan = cyc_i && stb_i && we_i && !ack_o && adr_i == 6'h00
                     && sel_i[0];
  // Busy runs from the handoff to the end of the exchange.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctl  <= 8'h00;
      busy <= 1'b0;
    end else begin
      if (scan)
        ctl <= dat_i[7:0];
      if (sdo_req_o && sdo_ack_i)
        busy <= 1'b1;
      else if (sdo_done_i)
        busy <= 1'b0;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_scan;
    scan;
  endsequence
  sequence s_handoff;
    sdo_req_o && sdo_ack_i;
  endsequence
  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack one cycle after request");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_run_gate: assert property (
    s_scan |-> ##2 run_o == (ctl[0] && ctl[2]))
    else $error("run output wrong after scan");
  chk_ctrl_copy: assert property (
    s_scan |-> ##2 {speed_command_op_lock_o, pause_o, quick_stop_o, servo_on_o,
    reverse_o} == ctl[5:1])
    else $error("control bits not copied after scan");
  chk_req_hold: assert property (
    sdo_req_o && !sdo_ack_i |=> sdo_req_o && $stable({sdo_write_o,
    sdo_node_o, sdo_index_o, sdo_sub_o}))
    else $error("request moved before ack");
  chk_req_drop: assert property (s_handoff |=> !sdo_req_o)
    else $error("request held after ack");
  chk_one_outstanding: assert property (busy |-> !sdo_req_o)
    else $error("second request while busy");
  chk_torque_cause: assert property (
    torque_clear_o |-> $past(scan))
    else $error("torque clear without scan");
  chk_limit_cause: assert property (
    limit_clear_o |-> $past(scan))
    else $error("limit clear without scan");
endmodule
bind speed_sdo_unit speed_sdo_chk chk_inst (.clk_i, .rst_i, .cyc_i,
  .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .ack_o, .run_o, .reverse_o,
  .servo_on_o, .quick_stop_o, .pause_o, .speed_command_op_lock_o, .torque_clear_o,
  .limit_clear_o, .sdo_req_o, .sdo_write_o, .sdo_node_o, .sdo_index_o,
  .sdo_sub_o, .sdo_ack_i, .sdo_done_i);

// ==== testbench/sdo_slave_model.sv ====
/* SDO engine and slave model.
   Assumes the unit holds each request until it sees ack. */
`timescale 1ns/1ps
module sdo_slave_model (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         bad_i,
  input  wire         req_i,
  input  wire [71:0]  ops_i,
  output logic        ack_o,
  output logic        done_o,
  output logic        error_o,
  output logic [31:0] rdata_o,
  output logic [63:0] info_o,
  output int          n_req_o
);
  logic        st;
  logic [3:0]  cnt;
  logic [71:0] lat;
  // Released answer lines toggle so stale data never looks valid.
  always @(posedge clk_i) begin
    ack_o   <= 1'b0;
    done_o  <= 1'b0;
    error_o <= ~error_o;
    rdata_o <= ~rdata_o;
    info_o  <= ~info_o;
    cnt     <= cnt + 4'h1;
    if (rst_i) begin
      st      <= 1'b0;
      cnt     <= 4'h0;
      n_req_o <= 0;
      error_o <= 1'b0;
      rdata_o <= 32'h0;
      info_o  <= 64'h0;
    end else if (!st) begin
      if (!req_i)
        cnt <= 4'h0;
      else if (cnt >= {bad_i, 2'h0}) begin
        ack_o   <= 1'b1;
        lat     <= ops_i;
        n_req_o <= n_req_o + 1;
        st      <= 1'b1;
        cnt     <= 4'h0;
      end
    end else if (cnt == {1'b0, bad_i, 2'h3}) begin
      done_o  <= 1'b1;
      error_o <= bad_i;
      rdata_o <= {lat[47:32], lat[63:48]} ^ {25'h0, lat[70:64]};
      info_o  <= {lat[31:0], lat[63:48], 8'h00, lat[71], lat[70:64]};
      st      <= 1'b0;
    end
  end
endmodule

// ==== testbench/drive_speed_and_sdo_command_unit_test.sv ====
/* Self-checking bench of speed_sdo_unit with an SDO slave model.
   Assumes the defines header and the checker are compiled with it. */
`timescale 1ns/1ps
`include "speed_sdo_defs.vh"
module drive_speed_and_sdo_command_unit_test;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [5:0]  adr_i = 6'h00;
  logic [3:0]  sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic        speed_command_op_reached_i = 1'b0;
  logic        bad = 1'b0;
  wire  [31:0] dat_o, sdo_wdata_o, sdo_rdata_i;
  wire  [15:0] speed_command_op_cmd_o, accel_time_o, decel_time_o, sdo_index_o, sdo_sub_o;
  wire  [6:0]  sdo_node_o;
  wire  [63:0] sdo_err_info_i;
  wire         ack_o, run_o, reverse_o, servo_on_o, quick_stop_o, pause_o;
  wire         speed_command_op_lock_o, torque_clear_o, limit_clear_o, sdo_req_o;
  wire         sdo_write_o, sdo_ack_i, sdo_done_i, sdo_error_i;
  int          n_errors = 0;
  int          tests_run = 0;
  int          n_tq = 0;
  int          n_lim = 0;
  int          n_req;
  logic [31:0] exp_q[$];
  speed_sdo_unit DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .speed_command_op_reached_i, .speed_command_op_cmd_o, .accel_time_o,
    .decel_time_o, .run_o, .reverse_o, .servo_on_o, .quick_stop_o, .pause_o,
    .speed_command_op_lock_o, .torque_clear_o, .limit_clear_o, .sdo_req_o, .sdo_write_o,
    .sdo_node_o, .sdo_index_o, .sdo_sub_o, .sdo_wdata_o, .sdo_ack_i,
    .sdo_done_i, .sdo_error_i, .sdo_rdata_i, .sdo_err_info_i);
  sdo_slave_model far_end (.clk_i, .rst_i, .bad_i(bad), .req_i(sdo_req_o),
    .ops_i({sdo_write_o, sdo_node_o, sdo_index_o, sdo_sub_o, sdo_wdata_o}),
    .ack_o(sdo_ack_i), .done_o(sdo_done_i), .error_o(sdo_error_i),
    .rdata_o(sdo_rdata_i), .info_o(sdo_err_info_i), .n_req_o(n_req));
  initial forever #5 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic print_verdict;
    $display("Counts: %0d compared, %0d mismatched", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_i) begin
    if (torque_clear_o === 1'b1)
      n_tq <= n_tq + 1;
    if (limit_clear_o === 1'b1)
      n_lim <= n_lim + 1;
    if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0)
      chk(dat_o, exp_q.pop_front());
  end
  initial begin
    logic [15:0] f, a, ix, sb;
    logic [31:0] wd, res, cmd;
    logic [63:0] err;
    logic [6:0]  nd;
    logic [5:0]  b;
    int          base;
    void'($urandom(75004));
    res = 32'h0;
    err = 64'h0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 64; i++) begin
      b = i[5:0];
      {f, a} = $urandom;
      wb(1'b1, `OFS_SPEED_COMMAND_OP, {16'h0000, f});
      wb(1'b1, `OFS_ACCEL, {16'h0000, a});
      wb(1'b1, `OFS_DECEL, {16'h0000, ~a});
      wb(1'b1, `OFS_CTRL, {25'h0, 1'b1, b});
      #1;
      chk({16'h0000, speed_command_op_cmd_o}, {16'h0000, f});
      chk({accel_time_o, decel_time_o}, {a, ~a});
      chk({speed_command_op_lock_o, pause_o, quick_stop_o, servo_on_o, reverse_o,
        run_o}, {b[5:1], b[0] & b[2]});
    end
    $display("Test scan_bits finished");
    wb(1'b1, `OFS_PRECLEAR, 32'h0000_0007);
    rd(`OFS_PRECLEAR, 32'h0000_0007);
    wb(1'b1, `OFS_CTRL, 32'h0);
    @(posedge clk_i);
    #1;
    chk({16'h0000, speed_command_op_cmd_o}, 32'h0);
    chk({n_tq[15:0], n_lim[15:0]}, 32'h0001_0001);
    wb(1'b1, `OFS_PRECLEAR, 32'h0);
    wb(1'b1, `OFS_CTRL, 32'h0000_0040);
    wb(1'b1, `OFS_CTRL, 32'h0);
    #1;
    chk({16'h0000, speed_command_op_cmd_o}, {16'h0000, f});
    $display("Test preclear finished");
    // Bad replies come slowly, so a second go lands while busy.
    for (int m = 0; m < 4; m++) begin
      {ix, sb} = $urandom;
      wd = $urandom;
      {nd, b} = 13'($urandom);
      speed_command_op_reached_i <= b[0];
      bad <= m[0];
      base = n_req;
      cmd = {29'h0, 1'b1, m[1], 1'b1};
      wb(1'b1, `OFS_SDO_NODE, {25'h0, nd});
      wb(1'b1, `OFS_SDO_INDEX, {16'h0000, ix});
      wb(1'b1, `OFS_SDO_SUB, {16'h0000, sb});
      wb(1'b1, `OFS_SDO_DATA, wd);
      wb(1'b1, `OFS_SDO_CMD, cmd);
      if (m[0]) begin
        wb(1'b1, `OFS_SDO_CMD, 32'h0);
        wb(1'b1, `OFS_SDO_CMD, cmd);
      end
      do @(posedge clk_i); while (sdo_done_i !== 1'b1);
      repeat (2) @(posedge clk_i);
      if (m[0])
        err = {wd, ix, 8'h00, m[1], nd};
      else if (!m[1])
        res = {sb, ix} ^ {25'h0, nd};
      rd(`OFS_STATUS, {29'h0, b[0], !m[0], 1'b1});
      if (!m[1])
        rd(`OFS_SDO_RESULT, res);
      for (int k = 0; k < 4; k++)
        rd(`OFS_ERR0 + 6'(4 * k), {16'h0000, err[16 * k +: 16]});
      chk(n_req - base, 1);
      wb(1'b1, `OFS_SDO_CMD, 32'h0);
    end
    bad <= 1'b0;
    base = n_req;
    wb(1'b1, `OFS_SDO_CMD, 32'h0000_0001);
    repeat (40) @(posedge clk_i);
    wb(1'b1, `OFS_SDO_CMD, 32'h0);
    repeat (20) @(posedge clk_i);
    chk(n_req - base > 2, 1);
    $display("Test sdo finished");
    print_verdict();
  end
  // The run needs about 1100 cycles; the 20000-cycle limit means a hang.
  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end
endmodule
